// ===== hw/ebpm_top.sv
// What this block does
// [RULE1] Bus-width strap low selects a 16-bit data bus, high an 8-bit bus.
// [RULE2] Board holds the width strap constant, grounded in single-chip use.
// [RULE3] Mode strap low starts single-chip, high starts microprocessor mode.
// [RULE4] The block is held in reset while the reset input is asserted.
// [RULE5] Five 8-bit ports, each pin's direction set individually by software.
// [RULE6] Software enables pull-ups on input pins in groups of four.
// [RULE7] Pull-ups are unavailable whenever the external bus is in use.
// [RULE8] Separate bus: first port carries D0-D7, second D8-D15 when 16-bit.
// [RULE9] Separate bus: third port drives address bits 0 to 7.
// [RULE10] Separate bus: fourth port drives address bits 8 to 15.
// [RULE11] 8-bit multiplexed: third port gives A0-A7 then carries D0-D7.
// [RULE12] 16-bit multiplexed: third port holds A0, shares A1-A7 with D0-D6.
// [RULE13] 16-bit multiplexed: fourth port shares A8 with D7, drives A9-A15.
// [RULE14] Bus in use: fifth port outputs four chip selects and A16-A19.
// [RULE15] Second port pins can serve as external interrupt request inputs.
// [RULE16] Split strobes: low-byte strobe writes even, high-byte odd, read strobe reads.
// [RULE17] Alternative scheme: one write strobe plus odd byte enable, software chosen.
// [RULE18] Hold request low enters hold with acknowledge low; ready low waits.
// [RULE19] Multiplexed buses give an address latch enable for the address phase.
// [RULE20] Single-chip mode: all pins are plain port pins, no bus signals.
// [RULE21] Both straps are sampled at reset release and held until next reset.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module ebpm_top (
  input  wire logic            CLOCK,
  input  wire logic            RESET,
  input  wire logic [7:0]      REG_ADDR,
  input  wire logic [7:0]      REG_WDATA,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  output logic      [7:0]      REG_RDATA,
  input  wire logic            BUS_WIDTH_STRAP,
  input  wire logic            PROCESSOR_MODE_STRAP,
  input  wire logic [4:0][7:0] IO_PORT_IN,
  output logic      [4:0][7:0] IO_PORT_OUT,
  output logic      [4:0][7:0] IO_PORT_OE,
  output logic      [4:0][7:0] IO_PORT_PULLUP,
  input  wire logic            BUS_REQ,
  input  wire logic            BUS_WE,
  input  wire logic [1:0]      BUS_BE,
  input  wire logic [19:0]     BUS_ADDR,
  input  wire logic [15:0]     BUS_WDATA,
  output logic                 BUS_ACCEPT,
  output logic                 BUS_DONE,
  output logic      [15:0]     BUS_RDATA,
  output logic                 LOW_BYTE_WRITE_STROBE_N,
  output logic                 HIGH_BYTE_WRITE_STROBE_N,
  output logic                 READ_STROBE_N,
  output logic                 ADDRESS_LATCH_ENABLE,
  output logic                 BUS_CTRL_OE,
  output logic                 BUS_HOLD_ACKNOWLEDGE_N,
  input  wire logic            HOLD_REQUEST_N,
  input  wire logic            READY_N,
  output logic      [7:0]      EXT_IRQ
);
  logic [4:0][7:0]    port_data;
  logic [4:0][7:0]    port_dir;
  logic [9:0]         pull_grp;
  logic [7:0]         bus_ctl;
  logic [7:0]         irq_en;
  logic               bus8;
  logic               mpu;
  logic               strap_taken;
  ebpm_pkg::ebpm_state_t state;
  ebpm_pkg::ebpm_state_t next_state;
  logic               cyc_we;
  logic [1:0]         cyc_be;
  logic [19:0]        cyc_addr;
  logic [15:0]        cyc_wdata;
  logic [4:0][7:0]    sel_w;
  logic [4:0][7:0]    out_w;
  logic [4:0][7:0]    oe_w;
  logic [4:0][7:0]    pin_q;

  ebpm_pin_if pif [5] ();

  function automatic logic [7:0] fill8(input logic b);
    fill8 = {8{b}};
  endfunction : fill8

  // Strap capture on the first edge after release
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin                                                   // [RULE4]
      strap_taken <= 1'b0;
      bus8        <= 1'b0;
      mpu         <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;                                             // [RULE21]
      bus8        <= BUS_WIDTH_STRAP;                                  // [RULE1] [RULE2]
      mpu         <= PROCESSOR_MODE_STRAP;                             // [RULE3]
    end
  end

  wire bus_on   = strap_taken & (mpu | bus_ctl[ebpm_pkg::CTL_EXP]);   // [RULE3] [RULE20]
  wire mux      = bus_ctl[ebpm_pkg::CTL_MUX];
  wire wr_bhe   = bus_ctl[ebpm_pkg::CTL_WRB];
  wire in_hold  = (state == ebpm_pkg::ST_HLD);
  wire addr_ph  = (state == ebpm_pkg::ST_ADDR);
  wire data_ph  = (state == ebpm_pkg::ST_DATA);
  wire in_cyc   = addr_ph | data_ph;
  wire wr_drv   = data_ph & cyc_we;
  wire rd_act   = data_ph & ~cyc_we;
  wire odd_only = cyc_be[1] & ~cyc_be[0];

  // Register port decode
  wire [2:0] pidx     = REG_ADDR[2:0];
  wire       hit_data = (REG_ADDR[7:3] == ebpm_pkg::ADR_DATA0[7:3]) && (pidx < 3'd5);
  wire       hit_dir  = (REG_ADDR[7:3] == ebpm_pkg::ADR_DIR0[7:3]) && (pidx < 3'd5);

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      port_data <= {5{ebpm_pkg::RST_DATA}};
      port_dir  <= {5{ebpm_pkg::RST_DIR}};
      pull_grp  <= {ebpm_pkg::RST_PULL[1:0], ebpm_pkg::RST_PULL};
      bus_ctl   <= ebpm_pkg::RST_BUSCTL;
      irq_en    <= ebpm_pkg::RST_IRQEN;
    end else if (REG_WR) begin
      if (hit_data) port_data[pidx] <= REG_WDATA;
      if (hit_dir) port_dir[pidx] <= REG_WDATA;                       // [RULE5]
      if (REG_ADDR == ebpm_pkg::ADR_PULL_LO) pull_grp[7:0] <= REG_WDATA;  // [RULE6]
      if (REG_ADDR == ebpm_pkg::ADR_PULL_HI) pull_grp[9:8] <= REG_WDATA[1:0];
      if (REG_ADDR == ebpm_pkg::ADR_BUSCTL) bus_ctl <= {5'h00, REG_WDATA[2:0]};
      if (REG_ADDR == ebpm_pkg::ADR_IRQEN) irq_en <= REG_WDATA;       // [RULE15]
    end
  end

  wire [7:0] status_w = {3'h0, strap_taken, in_hold, bus_on, mpu, bus8};
  wire [7:0] rd_mux   = hit_data ? pin_q[pidx] :
                        hit_dir ? port_dir[pidx] :
                        (REG_ADDR == ebpm_pkg::ADR_PULL_LO) ? pull_grp[7:0] :
                        (REG_ADDR == ebpm_pkg::ADR_PULL_HI) ? {6'h00, pull_grp[9:8]} :
                        (REG_ADDR == ebpm_pkg::ADR_BUSCTL) ? bus_ctl :
                        (REG_ADDR == ebpm_pkg::ADR_IRQEN) ? irq_en :
                        (REG_ADDR == ebpm_pkg::ADR_STATUS) ? status_w :
                        ebpm_pkg::RD_UNMAPPED;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) REG_RDATA <= 8'h00;
    else if (REG_RD) REG_RDATA <= rd_mux;
  end

  // Bus cycle sequencer; hold is granted only between cycles
  assign BUS_ACCEPT = bus_on & (state == ebpm_pkg::ST_IDLE) & HOLD_REQUEST_N;

  always_comb begin
    next_state = state;
    unique case (state)
      ebpm_pkg::ST_IDLE: begin
        if (bus_on && !HOLD_REQUEST_N) next_state = ebpm_pkg::ST_HLD;  // [RULE18]
        else if (BUS_REQ && BUS_ACCEPT) next_state = ebpm_pkg::ST_ADDR;
      end
      ebpm_pkg::ST_ADDR: next_state = ebpm_pkg::ST_DATA;
      ebpm_pkg::ST_DATA: begin
        if (!READY_N) next_state = ebpm_pkg::ST_DATA;                  // [RULE18]
        else next_state = ebpm_pkg::ST_IDLE;
      end
      ebpm_pkg::ST_HLD: begin
        if (HOLD_REQUEST_N) next_state = ebpm_pkg::ST_IDLE;            // [RULE18]
      end
    endcase
  end

  wire cyc_end = data_ph & READY_N;
  wire take    = BUS_REQ & BUS_ACCEPT;

  // Byte lane steering by bus width and address/data multiplexing
  wire [7:0] lo_wdata = (bus8 && odd_only) ? cyc_wdata[15:8] : cyc_wdata[7:0];
  wire [7:0] lo_rdata = (mux && !bus8) ? {pin_q[3][0], pin_q[2][7:1]} :
                        mux ? pin_q[2] : pin_q[0];
  wire [15:0] rd_word = bus8 ? {lo_rdata, lo_rdata} : {pin_q[1], lo_rdata};

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state     <= ebpm_pkg::ST_IDLE;
      cyc_we    <= 1'b0;
      cyc_be    <= 2'b00;
      cyc_addr  <= 20'h00000;
      cyc_wdata <= 16'h0000;
      BUS_DONE  <= 1'b0;
      BUS_RDATA <= 16'h0000;
    end else begin
      state    <= next_state;
      BUS_DONE <= cyc_end;
      if (take) begin
        cyc_we    <= BUS_WE;
        cyc_be    <= BUS_BE;
        cyc_addr  <= BUS_ADDR;
        cyc_wdata <= BUS_WDATA;
      end
      if (cyc_end && !cyc_we) BUS_RDATA <= rd_word;
    end
  end

  // Pin function selection per port
  wire [3:0] cs_n = ~(4'h1 << cyc_addr[ebpm_pkg::CS_HI:ebpm_pkg::CS_LO]);
  wire       drv  = bus_on & ~in_hold;

  assign sel_w[0] = fill8(bus_on & ~mux);                              // [RULE8] [RULE20]
  assign out_w[0] = lo_wdata;
  assign oe_w[0]  = fill8(drv & wr_drv);                               // [RULE8]

  assign sel_w[1] = fill8(bus_on & ~bus8);                             // [RULE8] [RULE1]
  assign out_w[1] = cyc_wdata[15:8];
  assign oe_w[1]  = fill8(drv & wr_drv);

  assign sel_w[2] = fill8(bus_on);
  assign out_w[2] = !mux ? cyc_addr[7:0] :                             // [RULE9]
                    bus8 ? (addr_ph ? cyc_addr[7:0] : lo_wdata) :      // [RULE11]
                    {(addr_ph ? cyc_addr[7:1] : cyc_wdata[6:0]), cyc_addr[0]};  // [RULE12]
  assign oe_w[2]  = !mux ? fill8(drv) :
                    bus8 ? fill8(drv & (addr_ph | wr_drv | ~in_cyc)) :
                    {{7{drv & (addr_ph | wr_drv | ~in_cyc)}}, drv};     // [RULE12]

  assign sel_w[3] = fill8(bus_on);
  assign out_w[3] = (!mux || bus8) ? cyc_addr[15:8] :                  // [RULE10]
                    {cyc_addr[15:9], (addr_ph ? cyc_addr[8] : cyc_wdata[7])};  // [RULE13]
  assign oe_w[3]  = (!mux || bus8) ? fill8(drv) :
                    {{7{drv}}, drv & (addr_ph | wr_drv | ~in_cyc)};     // [RULE13]

  assign sel_w[4] = fill8(bus_on);
  assign out_w[4] = {cyc_addr[19:16], (in_cyc ? cs_n : 4'hf)};         // [RULE14]
  assign oe_w[4]  = fill8(drv);

  genvar g;
  generate
    for (g = 0; g < ebpm_pkg::NUM_PORTS; g++) begin : g_port
      assign pif[g].gp_out   = port_data[g];
      assign pif[g].dir      = port_dir[g];
      assign pif[g].bus_sel  = sel_w[g];
      assign pif[g].bus_out  = out_w[g];
      assign pif[g].bus_oe   = oe_w[g];
      assign pif[g].pu_grp   = pull_grp[2*g+1:2*g];
      assign pif[g].pu_allow = ~bus_on;                                // [RULE7]
      assign pin_q[g]        = pif[g].pin_q;
      ebpm_port u_port (
        .clock   (CLOCK),
        .reset   (RESET),
        .pin_in  (IO_PORT_IN[g]),
        .pin_out (IO_PORT_OUT[g]),
        .pin_oe  (IO_PORT_OE[g]),
        .pull_up (IO_PORT_PULLUP[g]),
        .pif     (pif[g].pad)
      );
    end
  endgenerate

  // Strobes and control outputs
  wire wr_lo = wr_drv & (bus8 ? 1'b1 : cyc_be[0]);
  wire wr_hi = wr_drv & cyc_be[1];
  assign LOW_BYTE_WRITE_STROBE_N  = wr_bhe ? ~wr_drv : ~wr_lo;        // [RULE16] [RULE17]
  assign HIGH_BYTE_WRITE_STROBE_N = wr_bhe ? ~(in_cyc & cyc_be[1])   // [RULE17]
                                           : ~wr_hi;                  // [RULE16]
  assign READ_STROBE_N            = ~rd_act;                           // [RULE16]
  assign ADDRESS_LATCH_ENABLE     = bus_on & mux & addr_ph;            // [RULE19]
  assign BUS_CTRL_OE              = drv;                               // [RULE20]
  assign BUS_HOLD_ACKNOWLEDGE_N   = ~in_hold;                          // [RULE18]

  // External interrupt requests from second port, active low pins
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) EXT_IRQ <= 8'h00;
    else EXT_IRQ <= irq_en & ~pin_q[1] & ~sel_w[1];                    // [RULE15]
  end
endmodule : ebpm_top

// ===== hw/ebpm_pkg.sv
package ebpm_pkg;
  // Register byte addresses on the plain register port
  localparam logic [7:0] ADR_DATA0   = 8'h00;  // Port output latch / pin level, +n per port
  localparam logic [7:0] ADR_DIR0    = 8'h08;  // Port direction, +n per port
  localparam logic [7:0] ADR_PULL_LO = 8'h10;  // Pull-up groups, ports 0 to 3
  localparam logic [7:0] ADR_PULL_HI = 8'h11;  // Pull-up groups, port 4
  localparam logic [7:0] ADR_BUSCTL  = 8'h14;
  localparam logic [7:0] ADR_IRQEN   = 8'h15;
  localparam logic [7:0] ADR_STATUS  = 8'h18;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int         NUM_PORTS   = 5;
  localparam int         PORT_W      = 8;
  // Bus control fields
  localparam int CTL_MUX  = 0;  // 1: multiplexed address/data bus
  localparam int CTL_WRB  = 1;  // 1: single write strobe plus odd byte enable
  localparam int CTL_EXP  = 2;  // 1: memory expansion from single-chip start
  // Status fields
  localparam int ST_BUS8  = 0;
  localparam int ST_MPU   = 1;
  localparam int ST_BUSON = 2;
  localparam int ST_HOLD  = 3;
  localparam int ST_TAKEN = 4;
  // Reset values
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_PULL   = 8'h00;
  localparam logic [7:0] RST_BUSCTL = 8'h00;
  localparam logic [7:0] RST_IRQEN  = 8'h00;
  // Chip-select decode uses the top two address bits
  localparam int CS_HI = 19;
  localparam int CS_LO = 18;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_HLD  = 2'b11
  } ebpm_state_t;
endpackage : ebpm_pkg

// ===== hw/ebpm_pin_if.sv
interface ebpm_pin_if;
  logic [7:0] gp_out;
  logic [7:0] dir;
  logic [7:0] bus_sel;
  logic [7:0] bus_out;
  logic [7:0] bus_oe;
  logic [1:0] pu_grp;
  logic       pu_allow;
  logic [7:0] pin_q;
  modport ctl (output gp_out, dir, bus_sel, bus_out, bus_oe, pu_grp, pu_allow, input pin_q);
  modport pad (input gp_out, dir, bus_sel, bus_out, bus_oe, pu_grp, pu_allow, output pin_q);
endinterface : ebpm_pin_if

// ===== hw/ebpm_port.sv
module ebpm_port (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pull_up,
  ebpm_pin_if.pad         pif
);
  logic [7:0] pu_raw;

  // Bus function overrides the port bit by bit
  assign pin_out = (pif.bus_sel & pif.bus_out) | (~pif.bus_sel & pif.gp_out);   // [RULE5]
  assign pin_oe  = (pif.bus_sel & pif.bus_oe) | (~pif.bus_sel & pif.dir);       // [RULE5]
  // Pull-ups in nibbles, input pins only, never while the bus is on
  assign pu_raw  = {{4{pif.pu_grp[1]}}, {4{pif.pu_grp[0]}}};                     // [RULE6]
  assign pull_up = pu_raw & ~pif.dir & ~pif.bus_sel & {8{pif.pu_allow}};         // [RULE6] [RULE7]

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pif.pin_q <= 8'h00;
    end else begin
      pif.pin_q <= pin_in;
    end
  end
endmodule : ebpm_port

// ===== bench/ebpm_assertions.sv
module ebpm_assertions (
  input wire logic            CLOCK,
  input wire logic            RESET,
  input wire logic [4:0][7:0] IO_PORT_OE,
  input wire logic [4:0][7:0] IO_PORT_PULLUP,
  input wire logic            BUS_REQ,
  input wire logic            BUS_ACCEPT,
  input wire logic            BUS_DONE,
  input wire logic            LOW_BYTE_WRITE_STROBE_N,
  input wire logic            READ_STROBE_N,
  input wire logic            ADDRESS_LATCH_ENABLE,
  input wire logic            BUS_CTRL_OE,
  input wire logic            BUS_HOLD_ACKNOWLEDGE_N,
  input wire logic            HOLD_REQUEST_N,
  input wire logic            READY_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  property p_rst_quiet;
    $fell(RESET) |-> IO_PORT_OE == '0 && READ_STROBE_N && BUS_HOLD_ACKNOWLEDGE_N;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active at reset release");
  property p_rd_wr_excl;
    !READ_STROBE_N |-> LOW_BYTE_WRITE_STROBE_N;
  endproperty
  a_rd_wr_excl: assert property (p_rd_wr_excl)
    else $error("read and write strobe together");
  property p_done_time;
    BUS_REQ && BUS_ACCEPT ##2 READY_N |-> ##1 BUS_DONE;
  endproperty
  a_done_time: assert property (p_done_time)
    else $error("bus cycle length wrong");
  property p_done_quiet;
    BUS_DONE |-> READ_STROBE_N && LOW_BYTE_WRITE_STROBE_N;
  endproperty
  a_done_quiet: assert property (p_done_quiet)
    else $error("strobe still low at cycle end");
  property p_ale_port;
    ADDRESS_LATCH_ENABLE |-> IO_PORT_OE[2] == 8'hff && READ_STROBE_N;
  endproperty
  a_ale_port: assert property (p_ale_port)
    else $error("address phase not driven");
  property p_wr_addr;
    !LOW_BYTE_WRITE_STROBE_N |-> IO_PORT_OE[3] == 8'hff && IO_PORT_OE[4] == 8'hff;
  endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("upper address pins not driven");
  property p_ready_wait;
    !READ_STROBE_N && !READY_N |=> !READ_STROBE_N;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("wait ignored");
  property p_hold_ack;
    !BUS_HOLD_ACKNOWLEDGE_N |-> !$past(HOLD_REQUEST_N);
  endproperty
  a_hold_ack: assert property (p_hold_ack)
    else $error("hold acknowledge without request");
  property p_hold_float;
    !BUS_HOLD_ACKNOWLEDGE_N |-> !BUS_CTRL_OE && IO_PORT_OE[2] == 8'h00 && !BUS_ACCEPT;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("bus driven in hold");
  property p_pull_off;
    BUS_CTRL_OE |-> IO_PORT_PULLUP == '0;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull-up on with bus in use");
endmodule : ebpm_assertions

bind ebpm_top ebpm_assertions u_chk (.CLOCK(CLOCK), .RESET(RESET), .IO_PORT_OE(IO_PORT_OE),
  .IO_PORT_PULLUP(IO_PORT_PULLUP), .BUS_REQ(BUS_REQ), .BUS_ACCEPT(BUS_ACCEPT),
  .BUS_DONE(BUS_DONE), .LOW_BYTE_WRITE_STROBE_N(LOW_BYTE_WRITE_STROBE_N),
  .READ_STROBE_N(READ_STROBE_N), .ADDRESS_LATCH_ENABLE(ADDRESS_LATCH_ENABLE),
  .BUS_CTRL_OE(BUS_CTRL_OE), .BUS_HOLD_ACKNOWLEDGE_N(BUS_HOLD_ACKNOWLEDGE_N),
  .HOLD_REQUEST_N(HOLD_REQUEST_N), .READY_N(READY_N));

// ===== bench/ebpm_ext_mem.sv
module ebpm_ext_mem (
  input  wire logic            CLOCK,
  input  wire logic [4:0][7:0] IO_PORT_OUT,
  input  wire logic [4:0][7:0] IO_PORT_OE,
  input  wire logic [4:0][7:0] board_in,
  input  wire logic            READ_STROBE_N,
  input  wire logic            LOW_BYTE_WRITE_STROBE_N,
  input  wire logic            HIGH_BYTE_WRITE_STROBE_N,
  input  wire logic [15:0]     rd_word,
  input  wire logic [3:0]      wait_n,
  output logic      [4:0][7:0] IO_PORT_IN,
  output logic                 READY_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  wire logic act = !(READ_STROBE_N && LOW_BYTE_WRITE_STROBE_N && HIGH_BYTE_WRITE_STROBE_N);
  // Released lanes fall back to the board level, never the last data
  wire logic [4:0][7:0] ext = READ_STROBE_N ? board_in :
    {board_in[4:3], rd_word[7:0], rd_word[15:8], rd_word[7:0]};
  assign IO_PORT_IN = (IO_PORT_OE & IO_PORT_OUT) | (~IO_PORT_OE & ext);
  assign READY_N = !(act && cnt < wait_n);
  always_ff @(posedge CLOCK) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
  end
endmodule : ebpm_ext_mem

// ===== bench/ebpm_tb_top.sv
module ebpm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 0, RESET = 1, REG_WR = 0, REG_RD = 0, BUS_REQ = 0, BUS_WE = 0, HOLD_REQUEST_N = 1;
  logic BUS_WIDTH_STRAP = 0, PROCESSOR_MODE_STRAP = 0, BUS_ACCEPT, BUS_DONE, READY_N;
  logic LOW_BYTE_WRITE_STROBE_N, HIGH_BYTE_WRITE_STROBE_N, READ_STROBE_N;
  logic ADDRESS_LATCH_ENABLE, BUS_CTRL_OE, BUS_HOLD_ACKNOWLEDGE_N;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, EXT_IRQ;
  logic [1:0] BUS_BE = 0;
  logic [19:0] BUS_ADDR = 0;
  logic [15:0] BUS_WDATA = 0, BUS_RDATA, rd_word = 0, s_rd;
  logic [3:0] wait_n = 0;
  logic [2:0] s_str;
  logic [4:0][7:0] IO_PORT_IN, IO_PORT_OUT, IO_PORT_OE, IO_PORT_PULLUP, s_ale, s_dat;
  logic [4:0][7:0] board = 40'h00_00_00_fe_03;
  int fail_count = 0, total_checks = 0, s_n;
  ebpm_top u_dut (.CLOCK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .BUS_WIDTH_STRAP, .PROCESSOR_MODE_STRAP, .IO_PORT_IN, .IO_PORT_OUT, .IO_PORT_OE,
    .IO_PORT_PULLUP, .BUS_REQ, .BUS_WE, .BUS_BE, .BUS_ADDR, .BUS_WDATA, .BUS_ACCEPT, .BUS_DONE,
    .BUS_RDATA, .LOW_BYTE_WRITE_STROBE_N, .HIGH_BYTE_WRITE_STROBE_N, .READ_STROBE_N,
    .ADDRESS_LATCH_ENABLE, .BUS_CTRL_OE, .BUS_HOLD_ACKNOWLEDGE_N, .HOLD_REQUEST_N, .READY_N,
    .EXT_IRQ);
  ebpm_ext_mem u_mem (.CLOCK, .IO_PORT_OUT, .IO_PORT_OE, .board_in(board), .READ_STROBE_N,
    .LOW_BYTE_WRITE_STROBE_N, .HIGH_BYTE_WRITE_STROBE_N, .rd_word, .wait_n, .IO_PORT_IN,
    .READY_N);
  always #12.5 CLOCK = ~CLOCK;
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task ck(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : ck
  task rst(input logic w, input logic m);
    @(posedge CLOCK);
    RESET <= 1;
    BUS_WIDTH_STRAP <= w;
    PROCESSOR_MODE_STRAP <= m;
    repeat (4) @(posedge CLOCK);
    RESET <= 0;
    @(posedge CLOCK);
  endtask : rst
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    REG_RD <= 1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 0;
    @(negedge CLOCK);
    ck(REG_RDATA === e, "register read");
  endtask : rd
  // Holds the request until taken, then records the pins while ALE is high and while any strobe is low
  task bus(input logic we, input logic [1:0] be, input logic [19:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    BUS_REQ <= 1;
    BUS_WE <= we;
    BUS_BE <= be;
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    s_n = 0;
    @(negedge CLOCK);
    while (BUS_ACCEPT !== 1'b1 && s_n < 20) begin
      @(negedge CLOCK);
      s_n++;
    end
    @(posedge CLOCK);
    BUS_REQ <= 0;
    s_n = 0;
    do begin
      @(negedge CLOCK);
      s_n++;
      if (ADDRESS_LATCH_ENABLE === 1'b1) s_ale = IO_PORT_OUT;
      s_str = {LOW_BYTE_WRITE_STROBE_N, HIGH_BYTE_WRITE_STROBE_N, READ_STROBE_N};
      if (s_str !== 3'b111) s_dat = IO_PORT_OUT;
      if (s_str !== 3'b111 && s_n < 3) s_rd = {13'h0, s_str};
    end while (BUS_DONE !== 1'b1 && s_n < 20);
    s_str = s_rd[2:0];
    s_rd = BUS_RDATA;
  endtask : bus
  task t_single;
    rst(0, 0);
    wr(8'h08, 8'hf0);
    wr(8'h00, 8'ha5);
    wr(8'h10, 8'h01);
    wr(8'h15, 8'h01);
    repeat (4) @(negedge CLOCK);
    ck(IO_PORT_OE[0] === 8'hf0 && IO_PORT_OUT[0][7:4] === 4'ha, "direction");
    ck(IO_PORT_PULLUP[0] === 8'h0f, "pull-up group");
    ck(BUS_ACCEPT === 1'b0 && IO_PORT_OE[2] === 8'h00, "bus in single-chip");
    ck(BUS_CTRL_OE === 1'b0, "bus control in single-chip");
    ck(EXT_IRQ[0] === 1'b1, "irq low pin");
    rd(8'h00, 8'ha3);
    rd(8'h18, 8'h10);
    rd(8'h30, 8'h00);
    @(posedge CLOCK);
    board[1] <= 8'hff;
    repeat (4) @(negedge CLOCK);
    ck(EXT_IRQ[0] === 1'b0, "irq high pin");
    wr(8'h14, 8'h04);
    rd(8'h18, 8'h14);
    ck(IO_PORT_PULLUP[0] === 8'h00 && BUS_ACCEPT === 1'b1, "expansion mode");
  endtask : t_single
  task t_sep16;
    rst(0, 1);
    rd(8'h18, 8'h16);
    wr(8'h10, 8'hff);
    @(negedge CLOCK);
    ck(IO_PORT_PULLUP === '0, "pull-up with bus");
    bus(1, 2'b11, 20'h4_1234, 16'hbeef);
    ck(s_n === 3 && s_dat[0] === 8'hef && s_dat[1] === 8'hbe, "data lanes");
    ck(s_dat[2] === 8'h34 && s_dat[3] === 8'h12, "address lanes");
    ck(s_dat[4] === 8'h4d, "chip select and high address");
    wait_n <= 4'h2;
    rd_word <= 16'h5a3c;
    bus(0, 2'b11, 20'h0_0010, 16'h0000);
    ck(s_rd === 16'h5a3c && s_n === 5, "read with wait");
    @(posedge CLOCK);
    HOLD_REQUEST_N <= 0;
    repeat (3) @(negedge CLOCK);
    ck(BUS_HOLD_ACKNOWLEDGE_N === 1'b0 && BUS_ACCEPT === 1'b0, "hold");
    ck(BUS_CTRL_OE === 1'b0, "bus released in hold");
    @(posedge CLOCK);
    HOLD_REQUEST_N <= 1;
    wait_n <= 4'h0;
  endtask : t_sep16
  task t_mux8;
    rst(1, 1);
    rd(8'h18, 8'h17);
    wr(8'h14, 8'h01);
    bus(1, 2'b01, 20'h0_56c3, 16'h00a7);
    ck(s_ale[2] === 8'hc3 && s_dat[2] === 8'ha7, "multiplexed byte");
  endtask : t_mux8
  task t_mux16;
    logic [19:0] a;
    logic [15:0] d;
    a = 20'h0_a5c3;
    d = 16'h1234;
    rst(0, 1);
    wr(8'h14, 8'h01);
    bus(1, 2'b01, a, d);
    ck(s_dat[2] === {d[6:0], a[0]}, "third port word");
    ck(s_dat[3] === {a[15:9], d[7]}, "fourth port word");
    ck(s_str === 3'b011, "even byte strobe");
    wr(8'h14, 8'h03);
    bus(1, 2'b10, a, d);
    ck(s_str === 3'b001, "odd byte enable");
  endtask : t_mux16
  initial begin
    t_single();
    t_sep16();
    t_mux8();
    t_mux16();
    report_and_stop();
  end
  initial begin
    #100us;
    fail_count++;
    report_and_stop();
  end
endmodule : ebpm_tb_top
